// ===== common/fpso_pkg.sv
// Purpose: shared constants for the first fan output source/override block
// Assumes: 8-bit register port inside the device, 100 MHz system clock
// Notes: spin-up times are kept in milliseconds and scaled in the timer
package fpso_pkg;
  localparam logic [7:0] FPSO_ADDR_BIND = 8'hc8;
  localparam logic [7:0] FPSO_ADDR_OVR = 8'hc9;
  localparam logic [7:0] FPSO_ADDR_SPIN = 8'hca;
  localparam logic [7:0] FPSO_BIND_RESET = 8'h00;
  localparam logic [7:0] FPSO_OVR_RESET = 8'h00;
  localparam logic [7:0] FPSO_SPIN_RESET = 8'h00;
  localparam logic [7:0] FPSO_BIND_MASK = 8'h5f;
  localparam logic [7:0] FPSO_RD_UNMAPPED = 8'h00;
  // source-binding fields
  localparam int FPSO_BIND_ZONE_LSB = 0;
  localparam int FPSO_BIND_CPU_BIT = 4;
  localparam int FPSO_BIND_REG_BIT = 6;
  // override-control fields
  localparam int FPSO_OVR_EN_BIT = 0;
  localparam int FPSO_OVR_INV_BIT = 1;
  localparam int FPSO_OVR_LOCKEN_BIT = 2;
  localparam int FPSO_OVR_LOCK_BIT = 3;
  localparam int FPSO_OVR_CODE_LSB = 4;
  // spin-up fields
  localparam int FPSO_SPIN_CODE_LSB = 0;
  localparam int FPSO_SPIN_MSB_BIT = 4;
  localparam int FPSO_SPIN_LSBS_LSB = 5;
  localparam logic [3:0] FPSO_CODE_ZERO = 4'h0;
  localparam logic [3:0] FPSO_CODE_FULL = 4'hf;
  localparam int FPSO_NUM_ZONES = 4;
  localparam int FPSO_NUM_SRC = 7;
  // timing
  localparam int FPSO_CLK_PERIOD_NS = 10;
  localparam int FPSO_TICK_TIME_MS = 1;
  localparam int FPSO_MS_CYCLES =
    (FPSO_TICK_TIME_MS * 1000000) / FPSO_CLK_PERIOD_NS;
  localparam int FPSO_MS_WIDTH = 15;
  localparam logic [FPSO_MS_WIDTH-1:0] FPSO_SPINUP_MS [16] = '{
    15'h0000, 15'h0064, 15'h00fa, 15'h0190,
    15'h02bc, 15'h03e8, 15'h07d0, 15'h0fa0,
    15'h1770, 15'h1f40, 15'h2710, 15'h2ee0,
    15'h36b0, 15'h3e80, 15'h4650, 15'h4e20
  };
endpackage

// ===== rtl/fpso_duty_max.sv
// Purpose: pick the largest duty code among the enabled sources
// Assumes: codes packed four bits per source, source 0 in the low bits
// Notes: purely combinational; a disabled source counts as code zero
`timescale 1ns/1ps
`default_nettype none
module fpso_duty_max
  import fpso_pkg::*;
#(
  parameter int NUM_SRC = FPSO_NUM_SRC
) (
  input wire logic [NUM_SRC*4-1:0] src_codes,
  input wire logic [NUM_SRC-1:0] src_enable,
  output logic [3:0] max_code
);
  logic [3:0] chain [NUM_SRC+1];

  if (NUM_SRC < 1) begin : g_bad
    $error("fpso_duty_max needs at least one source");
  end

  assign chain[0] = FPSO_CODE_ZERO;
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    wire [3:0] cand = src_enable[i] ? src_codes[i*4 +: 4] : FPSO_CODE_ZERO;
    assign chain[i+1] = (cand > chain[i]) ? cand : chain[i];
  end
  assign max_code = chain[NUM_SRC];
endmodule
`default_nettype wire

// ===== rtl/fpso_spinup_timer.sv
// Purpose: time one spin-up burst from a 4-bit duration index
// Assumes: start is a single-cycle pulse on sys_clk
// Notes: a start during an active burst is ignored, never restarted
`timescale 1ns/1ps
`default_nettype none
module fpso_spinup_timer
  import fpso_pkg::*;
#(
  parameter int MS_CYCLES = FPSO_MS_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [3:0] dur_idx,
  output logic active
);
  logic [31:0] tick_reg;
  logic [FPSO_MS_WIDTH-1:0] left_reg;
  logic active_reg;
  // the start cycle already drives the spin-up duty, so the burst drops
  // one cycle early and the total stays the programmed time; the shortest
  // nonzero table entry is far above two, so the end point is always met
  localparam int TICK_LAST = (MS_CYCLES > 1) ? MS_CYCLES - 2 : 0;
  localparam logic [FPSO_MS_WIDTH-1:0] LEFT_LAST =
    (MS_CYCLES > 1) ? 15'h0001 : 15'h0002;
  wire tick_wrap = (tick_reg == 32'(MS_CYCLES - 1));
  wire last_cycle = (left_reg == LEFT_LAST) &&
                    (tick_reg == 32'(TICK_LAST));
  wire [FPSO_MS_WIDTH-1:0] load_ms = FPSO_SPINUP_MS[dur_idx];
  wire do_load = start && !active_reg && (load_ms != '0);

  if (MS_CYCLES < 1) begin : g_bad
    $error("fpso_spinup_timer needs MS_CYCLES of at least one");
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tick_reg <= 32'h0000_0000;
      left_reg <= '0;
      active_reg <= 1'b0;
    end else if (do_load) begin
      tick_reg <= 32'h0000_0000;
      left_reg <= load_ms;
      active_reg <= 1'b1;
    end else if (active_reg) begin
      tick_reg <= tick_wrap ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
      if (tick_wrap) begin
        left_reg <= left_reg - 1'b1;
      end
      if (last_cycle) begin
        active_reg <= 1'b0;
      end
    end
  end
  assign active = active_reg;
endmodule
`default_nettype wire

// ===== rtl/fpso_top.sv
// Purpose: duty source binding, override, lock and spin-up for fan output 1
// Assumes: register port and table/ramp codes come from logic on sys_clk;
//   the two hot alerts arrive from pins, active high after the pad
// Notes: duty codes run 0..15, 15 meaning full duty; the output pattern is
//   a simple 15-step compare that stands in for the frequency generator
//
// How it works
// - bits 3:0 of binding register attach zone tables a..d to output one.
// - binding bit 4 makes the processor-hot ramp a duty source.
// - binding bit 6 makes the regulator-hot ramp a duty source.
// - zones request via table codes, hot inputs via ramp codes.
// - several bound sources: output takes the largest requested duty.
// - override bit 0 enables manual duty from the 4-bit override field.
// - override never beats a larger request; output follows the maximum.
// - bit 1 clear: full duty is high; set: full duty is low.
// - with lock enable bit 2 set, bound processor-hot event sets flag bit 3.
// - while the lock flag is set the output runs at full duty, after any spin-up burst it starts.
// - software writes zero to the flag to release lock and resume.
// - the lock flag stays writable under the global configuration lock.
// - override code sits in bits 7:4; all 16 codes go to the output compare unmapped.
// - reading the override field returns the code now driven.
// - during spin-up the override field reads zero.
// - spin-up register bits 3:0 pick spin-up duty; zero disables spin-up.
// - duration msb is bit 4, lower three bits are bits 7:5.
// - duty leaving zero starts spin-up at spin-up duty for set duration.
`timescale 1ns/1ps
`default_nettype none
module fpso_top
  import fpso_pkg::*;
#(
  parameter int MS_CYCLES = FPSO_MS_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic cfg_lock_active,
  input wire logic [3:0] zone_code_a,
  input wire logic [3:0] zone_code_b,
  input wire logic [3:0] zone_code_c,
  input wire logic [3:0] zone_code_d,
  input wire logic [3:0] cpu_hot_ramp_code,
  input wire logic [3:0] regulator_hot_ramp_code,
  input wire logic cpu_hot_signal,
  input wire logic regulator_hot_signal,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic [3:0] pwm1_duty_code,
  output logic pwm1_out,
  output logic spinup_active,
  output logic regulator_hot_level
);
  typedef enum logic [2:0] {
    FPSO_RUN = 3'b001,
    FPSO_LOCKED = 3'b010,
    FPSO_SPIN = 3'b100
  } fpso_state_t;

  if (MS_CYCLES < 1) begin : g_bad
    $error("fpso_top needs MS_CYCLES of at least one");
  end

  // control registers
  logic [7:0] bind_reg;
  logic [3:0] ovr_code_reg;
  logic manual_override_en_reg;
  logic output_polarity_invert_reg;
  logic hot_lock_enable_reg;
  logic hot_lock_flag_reg;
  logic [7:0] spin_reg;

  // pin synchronisers: three stages, change accepted once 2 and 3 agree
  logic [2:0] cpu_sync_reg;
  logic [2:0] vrd_sync_reg;
  logic cpu_level_reg;
  logic vrd_level_reg;

  // output side
  logic [3:0] duty_code_reg;
  logic [3:0] pwm_cnt_reg;
  logic pwm_out_reg;
  logic prev_zero_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  fpso_state_t state_reg;
  fpso_state_t state_next;

  // register field views
  wire zone_table_bind_a = bind_reg[FPSO_BIND_ZONE_LSB];
  wire zone_table_bind_b = bind_reg[FPSO_BIND_ZONE_LSB + 1];
  wire zone_table_bind_c = bind_reg[FPSO_BIND_ZONE_LSB + 2];
  wire zone_table_bind_d = bind_reg[FPSO_BIND_ZONE_LSB + 3];
  wire cpu_hot_bind = bind_reg[FPSO_BIND_CPU_BIT];
  wire regulator_hot_bind = bind_reg[FPSO_BIND_REG_BIT];
  wire [3:0] spinup_duty_code = spin_reg[FPSO_SPIN_CODE_LSB +: 4];
  wire spinup_time_msb = spin_reg[FPSO_SPIN_MSB_BIT];
  wire [2:0] spinup_time_lsbs = spin_reg[FPSO_SPIN_LSBS_LSB +: 3];
  wire [3:0] spinup_dur_idx = {spinup_time_msb, spinup_time_lsbs};

  // register decode
  wire sel_bind = (reg_addr == FPSO_ADDR_BIND);
  wire sel_ovr = (reg_addr == FPSO_ADDR_OVR);
  wire sel_spin = (reg_addr == FPSO_ADDR_SPIN);
  // the global lock freezes settings but not the lock flag
  wire wr_open = reg_wr && !cfg_lock_active;
  wire wr_bind = wr_open && sel_bind;
  wire wr_ovr = wr_open && sel_ovr;
  wire wr_spin = wr_open && sel_spin;
  wire wr_lock_zero = reg_wr && sel_ovr &&
                      !reg_wdata[FPSO_OVR_LOCK_BIT];

  // processor-hot event: rising edge of the filtered level while bound
  wire cpu_level_next = (cpu_sync_reg[1] == cpu_sync_reg[2]) ?
                        cpu_sync_reg[2] : cpu_level_reg;
  wire vrd_level_next = (vrd_sync_reg[1] == vrd_sync_reg[2]) ?
                        vrd_sync_reg[2] : vrd_level_reg;
  wire cpu_hot_event = cpu_level_next && !cpu_level_reg && cpu_hot_bind;
  wire lock_set = cpu_hot_event && hot_lock_enable_reg;
  // set wins over a clearing write landing in the same cycle
  wire lock_next = lock_set ? 1'b1 :
                   (wr_lock_zero ? 1'b0 : hot_lock_flag_reg);

  // duty source selection
  wire [FPSO_NUM_SRC*4-1:0] src_codes = {
    ovr_code_reg,
    regulator_hot_ramp_code,
    cpu_hot_ramp_code,
    zone_code_d,
    zone_code_c,
    zone_code_b,
    zone_code_a
  };
  wire [FPSO_NUM_SRC-1:0] src_enable = {
    manual_override_en_reg,
    regulator_hot_bind,
    cpu_hot_bind,
    zone_table_bind_d,
    zone_table_bind_c,
    zone_table_bind_b,
    zone_table_bind_a
  };
  logic [3:0] max_code;
  // override is just one more candidate, so a larger request still wins
  fpso_duty_max #(
    .NUM_SRC(FPSO_NUM_SRC)
  ) u_max (
    .src_codes(src_codes),
    .src_enable(src_enable),
    .max_code(max_code)
  );

  // lock forces full duty ahead of the maximum
  wire [3:0] normal_code = hot_lock_flag_reg ? FPSO_CODE_FULL :
                           max_code;
  wire normal_zero = (normal_code == FPSO_CODE_ZERO);
  logic spinup_active_w;
  // a zero spin-up code or zero duration leaves the timer idle
  wire spin_start = prev_zero_reg && !normal_zero &&
                    (spinup_duty_code != FPSO_CODE_ZERO) &&
                    (FPSO_SPINUP_MS[spinup_dur_idx] != '0) &&
                    !spinup_active_w;
  fpso_spinup_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_spin (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(spin_start),
    .dur_idx(spinup_dur_idx),
    .active(spinup_active_w)
  );
  wire spinning = spin_start || spinup_active_w;
  wire [3:0] duty_next = spinning ? spinup_duty_code :
                         normal_code;

  // output pattern: code 15 keeps the compare true over the whole period
  wire pwm_wrap = (pwm_cnt_reg == (FPSO_CODE_FULL - 4'h1));
  wire [3:0] pwm_cnt_next = pwm_wrap ? 4'h0 : pwm_cnt_reg + 4'h1;
  wire pwm_raw = (pwm_cnt_reg < duty_code_reg);
  wire pwm_next = pwm_raw ^ output_polarity_invert_reg;

  // read-back mux
  wire [3:0] shown_code = spinup_active_w ? FPSO_CODE_ZERO :
                          duty_code_reg;
  wire [7:0] ovr_view = {
    shown_code,
    hot_lock_flag_reg,
    hot_lock_enable_reg,
    output_polarity_invert_reg,
    manual_override_en_reg
  };
  wire [7:0] rd_mux = sel_bind ? bind_reg :
                      sel_ovr ? ovr_view :
                      sel_spin ? spin_reg : FPSO_RD_UNMAPPED;

  // state summary for observation: spin outranks lock outranks run
  always_comb begin
    case (1'b1)
      spinning: state_next = FPSO_SPIN;
      hot_lock_flag_reg: state_next = FPSO_LOCKED;
      default: state_next = FPSO_RUN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bind_reg <= FPSO_BIND_RESET;
      spin_reg <= FPSO_SPIN_RESET;
      ovr_code_reg <= FPSO_OVR_RESET[FPSO_OVR_CODE_LSB +: 4];
      manual_override_en_reg <= FPSO_OVR_RESET[FPSO_OVR_EN_BIT];
      output_polarity_invert_reg <= FPSO_OVR_RESET[FPSO_OVR_INV_BIT];
      hot_lock_enable_reg <= FPSO_OVR_RESET[FPSO_OVR_LOCKEN_BIT];
      hot_lock_flag_reg <= FPSO_OVR_RESET[FPSO_OVR_LOCK_BIT];
    end else begin
      if (wr_bind) begin
        bind_reg <= reg_wdata & FPSO_BIND_MASK;
      end
      if (wr_spin) begin
        spin_reg <= reg_wdata;
      end
      if (wr_ovr) begin
        ovr_code_reg <= reg_wdata[FPSO_OVR_CODE_LSB +: 4];
        manual_override_en_reg <= reg_wdata[FPSO_OVR_EN_BIT];
        output_polarity_invert_reg <= reg_wdata[FPSO_OVR_INV_BIT];
        hot_lock_enable_reg <= reg_wdata[FPSO_OVR_LOCKEN_BIT];
      end
      hot_lock_flag_reg <= lock_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cpu_sync_reg <= 3'h0;
      vrd_sync_reg <= 3'h0;
      cpu_level_reg <= 1'b0;
      vrd_level_reg <= 1'b0;
    end else begin
      cpu_sync_reg <= {cpu_sync_reg[1:0], cpu_hot_signal};
      vrd_sync_reg <= {vrd_sync_reg[1:0], regulator_hot_signal};
      cpu_level_reg <= cpu_level_next;
      vrd_level_reg <= vrd_level_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      duty_code_reg <= FPSO_CODE_ZERO;
      prev_zero_reg <= 1'b1;
      pwm_cnt_reg <= 4'h0;
      pwm_out_reg <= 1'b0;
      state_reg <= FPSO_RUN;
    end else begin
      duty_code_reg <= duty_next;
      prev_zero_reg <= normal_zero;
      pwm_cnt_reg <= pwm_cnt_next;
      pwm_out_reg <= pwm_next;
      state_reg <= state_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_rd;
      if (reg_rd) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign pwm1_duty_code = duty_code_reg;
  assign pwm1_out = pwm_out_reg;
  // one-hot state, so the spin state is a flop bit of its own
  assign spinup_active = state_reg[2];
  assign regulator_hot_level = vrd_level_reg;
endmodule
`default_nettype wire

// ===== sim/fpso_chk.sv
// Purpose: port checks for the fan output one source block
// Assumes: register contents are seen only through read answers
// Notes: bound onto fpso_top after the module
`timescale 1ns/1ps
`default_nettype none
module fpso_chk
  import fpso_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [3:0] pwm1_duty_code,
  input wire logic pwm1_out,
  input wire logic spinup_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_RD_ANSWER: assert property (reg_rvalid == $past(reg_rd))
    else $error("read answer out of step");
  AST_RESET_QUIET: assert property ($rose(rst_n) |-> !pwm1_out
    && !spinup_active && pwm1_duty_code == 4'h0 ##1 pwm1_duty_code == 4'h0)
    else $error("outputs not quiet after reset");
  AST_BIND_RSVD: assert property (reg_rd && reg_addr == FPSO_ADDR_BIND
    |=> (reg_rdata & ~FPSO_BIND_MASK) == 8'h00)
    else $error("reserved binding bits read set");
  AST_RD_CODE: assert property (reg_rvalid && !spinup_active
    && $past(reg_addr) == FPSO_ADDR_OVR
    |-> reg_rdata[7:4] == $past(pwm1_duty_code))
    else $error("override field is not the driven code");
  AST_RD_SPIN: assert property (reg_rvalid && spinup_active
    && $past(reg_addr) == FPSO_ADDR_OVR |-> reg_rdata[7:4] == 4'h0)
    else $error("override field not zero in spin-up");
  AST_SPIN_NZ: assert property (spinup_active
    |-> pwm1_duty_code != 4'h0)
    else $error("spin-up running at zero duty");
  AST_SPIN_HOLD: assert property (spinup_active && $past(spinup_active)
    |-> $stable(pwm1_duty_code))
    else $error("duty moved during spin-up");
  AST_SPIN_START: assert property ($rose(spinup_active)
    |-> $past(pwm1_duty_code, 2) == 4'h0)
    else $error("spin-up began from nonzero duty");
  AST_PWM_STEADY: assert property (((pwm1_duty_code == 4'hf
    || pwm1_duty_code == 4'h0) && $stable(pwm1_duty_code) && !reg_wr)[*3]
    |-> $stable(pwm1_out))
    else $error("output toggles at zero or full duty");
endmodule
bind fpso_top fpso_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .pwm1_duty_code(pwm1_duty_code), .pwm1_out(pwm1_out),
  .spinup_active(spinup_active));
`default_nettype wire

// ===== sim/fpso_partner.sv
// Purpose: thermal alert pins and ramp generators at the far side
// Assumes: the bench raises cpu_req and reg_req off the clock edge
// Notes: ramps move one code a cycle, a stand-in for the real slopes
`timescale 1ns/1ps
`default_nettype none
module fpso_partner (
  input wire logic sys_clk,
  input wire logic cpu_req,
  input wire logic reg_req,
  output logic cpu_hot_signal,
  output logic regulator_hot_signal,
  output logic [3:0] cpu_hot_ramp_code,
  output logic [3:0] regulator_hot_ramp_code
);
  function automatic logic [3:0] step(input logic up, input logic [3:0] c);
    if (up) return (c == 4'hf) ? c : c + 4'h1;
    return (c == 4'h0) ? c : c - 4'h1;
  endfunction
  initial begin
    {cpu_hot_signal, regulator_hot_signal} = 2'h0;
    {cpu_hot_ramp_code, regulator_hot_ramp_code} = 8'h00;
  end
  // rising edge, non-blocking: the bench moves requests at the falling
  // edge, so they are never raced, and the block sees each change settled
  always @(posedge sys_clk) begin
    cpu_hot_signal <= cpu_req;
    regulator_hot_signal <= reg_req;
    cpu_hot_ramp_code <= step(cpu_req, cpu_hot_ramp_code);
    regulator_hot_ramp_code <= step(reg_req, regulator_hot_ramp_code);
  end
endmodule
`default_nettype wire

// ===== sim/test_fan_pwm_source_override_spinup.sv
// Purpose: self-checking bench for the fan output one source block
// Assumes: MS_CYCLES cut to 1, so the longest spin-up tested is 6000 cycles
// Notes: inputs move at the falling edge only
`timescale 1ns/1ps
`default_nettype none
module test_fan_pwm_source_override_spinup;
  import fpso_pkg::*;
  localparam int MSC = 1;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cfg_lock_active = 1'b0;
  logic cpu_req = 1'b0;
  logic reg_req = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [3:0] zc [4] = '{default: 4'h0};
  logic cpu_hot_signal, regulator_hot_signal, reg_rvalid, pwm1_out;
  logic spinup_active, regulator_hot_level;
  logic [3:0] cpu_hot_ramp_code, regulator_hot_ramp_code, pwm1_duty_code;
  logic [7:0] reg_rdata, rd_val, b, o;
  logic [7:0] pat [6] = '{8'h03, 8'h73, 8'hf3, 8'h01, 8'h71, 8'hf1};
  logic [7:0] spn [3] = '{8'h2c, 8'h1c, 8'h20};
  int err_total = 0;
  int compares = 0;
  int hi_cnt = 0;
  int n, e;
  fpso_top #(.MS_CYCLES(MSC)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .cfg_lock_active(cfg_lock_active),
    .zone_code_a(zc[0]), .zone_code_b(zc[1]), .zone_code_c(zc[2]),
    .zone_code_d(zc[3]), .cpu_hot_ramp_code(cpu_hot_ramp_code),
    .regulator_hot_ramp_code(regulator_hot_ramp_code),
    .cpu_hot_signal(cpu_hot_signal),
    .regulator_hot_signal(regulator_hot_signal), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .pwm1_duty_code(pwm1_duty_code),
    .pwm1_out(pwm1_out), .spinup_active(spinup_active),
    .regulator_hot_level(regulator_hot_level));
  fpso_partner u_far (.sys_clk(sys_clk), .cpu_req(cpu_req),
    .reg_req(reg_req), .cpu_hot_signal(cpu_hot_signal),
    .regulator_hot_signal(regulator_hot_signal),
    .cpu_hot_ramp_code(cpu_hot_ramp_code),
    .regulator_hot_ramp_code(regulator_hot_ramp_code));
  always #5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (spinup_active === 1'b1) hi_cnt++;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    rd_val = reg_rdata;
  endtask
  task automatic wait_n(input int c);
    repeat (c) @(negedge sys_clk);
  endtask
  function automatic logic [3:0] exp_max(input logic [7:0] bb,
                                         input logic [7:0] oo);
    logic [3:0] m;
    m = oo[0] ? oo[7:4] : 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (bb[i] && zc[i] > m) m = zc[i];
    end
    if (bb[4] && cpu_hot_ramp_code > m) m = cpu_hot_ramp_code;
    if (bb[6] && regulator_hot_ramp_code > m) m = regulator_hot_ramp_code;
    return m;
  endfunction
  task automatic end_sim;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #300000;
    err_total++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h19bd));
    wait_n(5);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(8'hc8 + 8'(i));
      check(16'(rd_val), 16'h0);
    end
    wr(FPSO_ADDR_BIND, 8'hff);
    rd(FPSO_ADDR_BIND);
    check(16'(rd_val), 16'(FPSO_BIND_MASK));
    $display("test reset and map done");
    for (int i = 0; i < 16; i++) begin
      b = 8'($urandom) & FPSO_BIND_MASK;
      o = {4'(i), 3'b000, 1'($urandom)};
      foreach (zc[j]) zc[j] = 4'($urandom);
      wr(FPSO_ADDR_BIND, b);
      wr(FPSO_ADDR_OVR, o);
      wait_n(3);
      check(16'(pwm1_duty_code), 16'(exp_max(b, o)));
      rd(FPSO_ADDR_OVR);
      check(16'(rd_val), 16'({exp_max(b, o), o[3:0]}));
    end
    $display("test source maximum done");
    zc = '{default: 4'h0};
    wr(FPSO_ADDR_BIND, 8'h00);
    foreach (pat[k]) begin
      wr(FPSO_ADDR_OVR, pat[k]);
      wait_n(3);
      n = 0;
      repeat (15) begin
        @(negedge sys_clk);
        if (pwm1_out === 1'b1) n++;
      end
      e = pat[k][1] ? 15 - int'(pat[k][7:4]) : int'(pat[k][7:4]);
      check(16'(n), 16'(e));
    end
    $display("test output pattern done");
    wr(FPSO_ADDR_OVR, 8'h04);
    wr(FPSO_ADDR_BIND, 8'h10);
    for (int i = 0; i < 2; i++) begin
      // only the pin moves; no register is written while it is high
      cpu_req = 1'b1;
      wait_n(20);
      check(16'(pwm1_duty_code), 16'hf);
      cpu_req = 1'b0;
      wait_n(20);
      rd(FPSO_ADDR_OVR);
      check(16'(rd_val), (i == 0) ? 16'hfc : 16'h00);
      cfg_lock_active = (i == 0);
      wr(FPSO_ADDR_OVR, 8'h00);
      wait_n(3);
      rd(FPSO_ADDR_OVR);
      check(16'(rd_val), (i == 0) ? 16'h04 : 16'h00);
      cfg_lock_active = 1'b0;
      wr(FPSO_ADDR_OVR, 8'h00);
    end
    wr(FPSO_ADDR_BIND, 8'h40);
    reg_req = 1'b1;
    wait_n(20);
    check(16'({regulator_hot_level, pwm1_duty_code}), 16'h1f);
    wr(FPSO_ADDR_BIND, 8'h00);
    wait_n(3);
    check(16'(pwm1_duty_code), 16'h0);
    reg_req = 1'b0;
    $display("test hot inputs and lock done");
    foreach (spn[k]) begin
      wr(FPSO_ADDR_OVR, 8'h00);
      wr(FPSO_ADDR_SPIN, spn[k]);
      wait_n(3);
      hi_cnt = 0;
      wr(FPSO_ADDR_OVR, 8'h31);
      wait_n(4);
      e = (spn[k][3:0] != 4'h0) ? int'(spn[k][3:0]) : 3;
      check(16'(pwm1_duty_code), 16'(e));
      rd(FPSO_ADDR_OVR);
      check(16'(rd_val[7:4]), (e == 3) ? 16'h3 : 16'h0);
      for (n = 0; spinup_active !== 1'b0 && n < 7000; n++) wait_n(1);
      check(16'(n < 7000), 16'h1);
      wait_n(2);
      e = (e == 3) ? 0 : MSC * int'(FPSO_SPINUP_MS[{spn[k][4], spn[k][7:5]}]);
      check(16'(hi_cnt), 16'(e));
      check(16'(pwm1_duty_code), 16'h3);
    end
    $display("test spin-up done");
    end_sim();
  end
endmodule
`default_nettype wire
